// *** logic/dsmo_pkg.sv ***
/*
 Constants and types for the drive status and mode
 objects block: object indices, status bit positions, reset values and
 the drive state codes.
 Assumes a surrounding object server that hands single object accesses
 to the block and a drive state machine that reports its state.
*/
package dsmo_pkg;

   // Object indices
   localparam logic [15:0] IDX_EXT_STATUS = 16'h1002;
   localparam logic [15:0] IDX_STATUS_WORD = 16'h6041;
   localparam logic [15:0] IDX_MODE_SELECT = 16'h6060;
   localparam logic [15:0] IDX_MODE_DISPLAY = 16'h6061;

   // Status word bit positions
   localparam int unsigned SW_AXIS_ON = 15;
   localparam int unsigned SW_EVENT = 14;
   localparam int unsigned SW_MODE_LO = 12;
   localparam int unsigned SW_INT_LIMIT = 11;
   localparam int unsigned SW_TARGET = 10;
   localparam int unsigned SW_REMOTE = 9;
   localparam int unsigned SW_FUNC_BUSY = 8;
   localparam int unsigned SW_WARNING = 7;
   localparam int unsigned SW_SWITCH_DIS = 6;
   localparam int unsigned SW_QSTOP = 5;
   localparam int unsigned SW_VOLTAGE = 4;
   localparam int unsigned SW_FAULT = 3;

   // Extended status bit positions
   localparam int unsigned VS_FAULT = 31;
   localparam int unsigned VS_CAM = 30;
   localparam int unsigned VS_RESERVED = 29;
   localparam int unsigned VS_GEAR = 28;
   localparam int unsigned VS_DRV_OVL = 27;
   localparam int unsigned VS_MOT_OVL = 26;
   localparam int unsigned VS_TARGET = 25;
   localparam int unsigned VS_CAPTURE = 24;
   localparam int unsigned VS_LIM_NEG = 23;
   localparam int unsigned VS_LIM_POS = 22;
   localparam int unsigned VS_AUTOSTART = 21;
   localparam int unsigned VS_TRIG_LO = 17;
   localparam int unsigned VS_INIT = 16;

   // Reset values and codes
   localparam logic signed [7:0] MODE_SELECT_RESET = 8'sh00;
   localparam logic [15:0] ERR_WRONG_MODE = 16'hff04;
   localparam logic [3:0] QS_OPT_MIN = 4'h5;
   localparam logic [3:0] QS_OPT_MAX = 4'h8;

   // Mode codes
   localparam logic signed [7:0] MODE_NONE = 8'sh00;
   localparam logic signed [7:0] MODE_PROF_POS = 8'sh01;
   localparam logic signed [7:0] MODE_PROF_VEL = 8'sh03;
   localparam logic signed [7:0] MODE_HOMING = 8'sh06;
   localparam logic signed [7:0] MODE_INTERP_POS = 8'sh07;
   localparam logic signed [7:0] MODE_CYCLIC_POS = 8'sh08;
   localparam logic signed [7:0] MODE_CYCLIC_VEL = 8'sh09;
   localparam logic signed [7:0] MODE_CYCLIC_TRQ = 8'sh0a;
   localparam logic signed [7:0] MODE_VND_LOW = -8'sh05;
   localparam logic signed [7:0] MODE_VND_HIGH = -8'sh01;

   // Drive states, Gray along the power-up path
   typedef enum logic [2:0] {
      DS_NOT_READY = 3'h0,
      DS_SWITCH_DIS = 3'h1,
      DS_READY = 3'h3,
      DS_SWITCHED_ON = 3'h2,
      DS_OP_ENABLED = 3'h6,
      DS_QSTOP_ACTIVE = 3'h7,
      DS_FAULT_REACT = 3'h5,
      DS_FAULT = 3'h4
   } dsmo_drive_state_t;

endpackage : dsmo_pkg

// *** logic/dsmo_status_mode.sv ***
/*
 Status word, extended status register, operating mode selector and
 mode display objects of a servo drive object dictionary.
 Assumes all inputs are synchronous to CLK_I (driven by drive logic on
 the same clock) and that the object server offers one access per
 request pulse and waits for the acknowledge.
*/
`timescale 1ns/100ps
module dsmo_status_mode
   import dsmo_pkg::*;
#(
   parameter int QS_OPT_W = 4
) (
   // Clock, reset, enable
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   // Object access
   input wire logic OBJ_REQ_I,
   input wire logic OBJ_WE_I,
   input wire logic [15:0] OBJ_INDEX_I,
   input wire logic [31:0] OBJ_WDATA_I,
   output logic OBJ_ACK_O,
   output logic OBJ_NACK_O,
   output logic [31:0] OBJ_RDATA_O,
   output logic CMD_ERR_O,
   output logic [15:0] ERR_CODE_O,
   // Drive state and status sources
   input wire logic [2:0] DRIVE_STATE_I,
   input wire logic POWER_ON_I,
   input wire logic EVENT_HIT_I,
   input wire logic [1:0] MODE_BITS_I,
   input wire logic INT_LIMIT_I,
   input wire logic REMOTE_I,
   input wire logic HV_PRESENT_I,
   input wire logic FAULT_I,
   input wire logic FAULT_RESET_CTRL_I,
   // Function and homing calls
   input wire logic FUNC_CALL_I,
   input wire logic FUNC_DONE_I,
   input wire logic FUNC_ABORT_I,
   output logic FUNC_ACCEPT_O,
   // Target reached sources
   input wire logic SETPOINT_REACHED_I,
   input wire logic NEW_TARGET_I,
   input wire logic [QS_OPT_W-1:0] QS_OPTION_I,
   input wire logic QSTOP_DONE_I,
   input wire logic HALT_I,
   input wire logic STANDSTILL_I,
   // Vendor event sources
   input wire logic CAM_REACHED_I,
   input wire logic GEAR_REACHED_I,
   input wire logic DRV_OVL_WARN_I,
   input wire logic MOT_OVL_WARN_I,
   input wire logic CAPTURE_I,
   input wire logic LIM_NEG_I,
   input wire logic LIM_POS_I,
   input wire logic AUTOSTART_MODE_I,
   input wire logic [3:0] POS_TRIG_I,
   input wire logic INIT_DONE_I,
   // Object values
   output logic [15:0] STATUS_WORD_O,
   output logic [31:0] EXT_STATUS_O,
   output logic signed [7:0] MODE_SELECT_O,
   output logic signed [7:0] MODE_DISPLAY_O
);

   if (QS_OPT_W < 4 || QS_OPT_W > 16) begin : g_chk
      $error("QS_OPT_W must lie between 4 and 16");
   end

   typedef struct packed {
      logic [15:0] status;
      logic [31:0] ext;
      logic signed [7:0] mode_sel;
      logic signed [7:0] mode_act;
      logic busy;
      logic warn;
      logic fault;
      logic target;
      logic fr_prev;
      logic ack;
      logic nack;
      logic cmd_err;
      logic [31:0] rdata;
      logic [15:0] err_code;
   } dsmo_state_t;

   dsmo_state_t s;
   dsmo_state_t next_s;

   // Codes outside these ranges select nothing
   function automatic logic mode_supported(input logic signed [7:0] m);
      logic ok;
      ok = 1'b0;
      if (m >= MODE_VND_LOW && m <= MODE_VND_HIGH) begin
         ok = 1'b1;
      end
      unique case (m)
         MODE_NONE, MODE_PROF_POS, MODE_PROF_VEL, MODE_HOMING,
         MODE_INTERP_POS, MODE_CYCLIC_POS, MODE_CYCLIC_VEL,
         MODE_CYCLIC_TRQ: ok = 1'b1;
         default: ;
      endcase
      return ok;
   endfunction : mode_supported

   // Returns bits {6,5,3,2,1,0}; don't-care bits read as zero
   function automatic logic [5:0] state_bits(input logic [2:0] st);
      logic [5:0] b;
      b = 6'h00;
      unique case (dsmo_drive_state_t'(st))
         DS_NOT_READY: b = 6'h00;
         DS_SWITCH_DIS: b = 6'h20;
         DS_READY: b = 6'h11;
         DS_SWITCHED_ON: b = 6'h13;
         DS_OP_ENABLED: b = 6'h17;
         DS_QSTOP_ACTIVE: b = 6'h07;
         DS_FAULT_REACT: b = 6'h0f;
         DS_FAULT: b = 6'h08;
      endcase
      return b;
   endfunction : state_bits

   logic fr_rise;
   logic mode_chg;
   logic qs_opt_ok;
   logic [5:0] sb;
   logic [15:0] sw;
   logic signed [7:0] wcode;

   assign FUNC_ACCEPT_O = FUNC_CALL_I & ~s.busy;

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.nack = 1'b0;
      next_s.cmd_err = 1'b0;
      mode_chg = 1'b0;
      wcode = OBJ_WDATA_I[7:0];
      fr_rise = FAULT_RESET_CTRL_I & ~s.fr_prev;
      next_s.fr_prev = FAULT_RESET_CTRL_I;

      // Object access; reads see the current registered snapshot
      if (OBJ_REQ_I) begin
         next_s.ack = 1'b1;
         unique case (OBJ_INDEX_I)
            IDX_EXT_STATUS: begin
               next_s.rdata = s.ext;
               next_s.nack = OBJ_WE_I;
            end
            IDX_STATUS_WORD: begin
               next_s.rdata = {16'h0000, s.status};
               next_s.nack = OBJ_WE_I;
            end
            IDX_MODE_DISPLAY: begin
               next_s.rdata = {{24{s.mode_act[7]}}, s.mode_act};
               next_s.nack = OBJ_WE_I;
            end
            IDX_MODE_SELECT: begin
               if (!OBJ_WE_I) begin
                  next_s.rdata = {{24{s.mode_sel[7]}}, s.mode_sel};
               end else if (mode_supported(wcode)) begin
                  next_s.mode_sel = wcode;
                  // Zero means no change, so the active mode stays
                  if (wcode != MODE_NONE && wcode != s.mode_act) begin
                     next_s.mode_act = wcode;
                     mode_chg = 1'b1;
                  end
               end else begin
                  next_s.nack = 1'b1;
                  next_s.cmd_err = 1'b1;
                  next_s.err_code = ERR_WRONG_MODE;
               end
            end
            default: next_s.nack = 1'b1;
         endcase
      end

      // Function or homing busy; a call while busy is dropped
      if (FUNC_DONE_I || FUNC_ABORT_I) begin
         next_s.busy = 1'b0;
      end
      if (FUNC_CALL_I && !s.busy) begin
         next_s.busy = 1'b1;
      end
      if (fr_rise) begin
         next_s.warn = 1'b0;
      end
      if (FUNC_CALL_I && s.busy) begin
         next_s.warn = 1'b1;
         next_s.cmd_err = 1'b1;
      end

      // Fault latch: a fault still present survives the reset edge
      if (fr_rise && !FAULT_I) begin
         next_s.fault = 1'b0;
      end
      if (FAULT_I) begin
         next_s.fault = 1'b1;
      end

      // Target reached; any set source beats a new target
      qs_opt_ok = QS_OPTION_I >= QS_OPT_W'(QS_OPT_MIN) &&
                  QS_OPTION_I <= QS_OPT_W'(QS_OPT_MAX);
      if (NEW_TARGET_I) begin
         next_s.target = 1'b0;
      end
      if (SETPOINT_REACHED_I) begin
         next_s.target = 1'b1;
      end
      if (mode_chg) begin
         next_s.target = 1'b1;
      end
      if (qs_opt_ok && QSTOP_DONE_I && STANDSTILL_I) begin
         next_s.target = 1'b1;
      end
      if (HALT_I && STANDSTILL_I) begin
         next_s.target = 1'b1;
      end

      // Status built from next state so every object moves together
      sb = state_bits(DRIVE_STATE_I);
      sw = {9'h000, sb[5:4], 1'b0, sb[3:0]};
      sw[SW_AXIS_ON] = POWER_ON_I;
      sw[SW_EVENT] = EVENT_HIT_I;
      sw[SW_MODE_LO +: 2] = MODE_BITS_I;
      sw[SW_INT_LIMIT] = INT_LIMIT_I;
      sw[SW_TARGET] = next_s.target;
      sw[SW_REMOTE] = REMOTE_I;
      sw[SW_FUNC_BUSY] = next_s.busy;
      sw[SW_WARNING] = next_s.warn;
      sw[SW_VOLTAGE] = HV_PRESENT_I;
      sw[SW_FAULT] = sb[3] | next_s.fault;
      next_s.status = sw;

      next_s.ext = {16'h0000, sw};
      next_s.ext[VS_FAULT] = next_s.fault;
      next_s.ext[VS_CAM] = CAM_REACHED_I;
      next_s.ext[VS_RESERVED] = 1'b0;
      next_s.ext[VS_GEAR] = GEAR_REACHED_I;
      next_s.ext[VS_DRV_OVL] = DRV_OVL_WARN_I;
      next_s.ext[VS_MOT_OVL] = MOT_OVL_WARN_I;
      next_s.ext[VS_TARGET] = next_s.target;
      next_s.ext[VS_CAPTURE] = CAPTURE_I;
      next_s.ext[VS_LIM_NEG] = LIM_NEG_I;
      next_s.ext[VS_LIM_POS] = LIM_POS_I;
      next_s.ext[VS_AUTOSTART] = AUTOSTART_MODE_I;
      next_s.ext[VS_TRIG_LO +: 4] = POS_TRIG_I;
      next_s.ext[VS_INIT] = INIT_DONE_I;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s <= '0;
         s.mode_sel <= MODE_SELECT_RESET;
         s.mode_act <= MODE_SELECT_RESET;
      end else if (CE_I) begin
         s <= next_s;
      end
   end

   assign OBJ_ACK_O = s.ack;
   assign OBJ_NACK_O = s.nack;
   assign OBJ_RDATA_O = s.rdata;
   assign CMD_ERR_O = s.cmd_err;
   assign ERR_CODE_O = s.err_code;
   assign STATUS_WORD_O = s.status;
   assign EXT_STATUS_O = s.ext;
   assign MODE_SELECT_O = s.mode_sel;
   assign MODE_DISPLAY_O = s.mode_act;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_call_while_busy;
      CE_I && FUNC_CALL_I && s.busy;
   endsequence

   sequence s_bad_mode_write;
      CE_I && OBJ_REQ_I && OBJ_WE_I && OBJ_INDEX_I == IDX_MODE_SELECT &&
      !mode_supported(OBJ_WDATA_I[7:0]);
   endsequence

   sequence s_good_mode_change;
      CE_I && OBJ_REQ_I && OBJ_WE_I && OBJ_INDEX_I == IDX_MODE_SELECT &&
      mode_supported(OBJ_WDATA_I[7:0]) &&
      OBJ_WDATA_I[7:0] != MODE_NONE && OBJ_WDATA_I[7:0] != s.mode_act;
   endsequence

   a_axis_on_bit: assert property (
      CE_I |=> STATUS_WORD_O[SW_AXIS_ON] == $past(POWER_ON_I))
      else $error("axis on bit does not follow power stage");

   a_call_busy_warn: assert property (
      s_call_while_busy |=> STATUS_WORD_O[SW_WARNING] &&
      STATUS_WORD_O[SW_FUNC_BUSY] && CMD_ERR_O)
      else $error("call while busy did not warn");

   a_call_start_busy: assert property (
      CE_I && FUNC_ACCEPT_O && !FUNC_DONE_I |=> STATUS_WORD_O[SW_FUNC_BUSY])
      else $error("accepted call did not show busy");

   a_bad_mode_keep: assert property (
      s_bad_mode_write |=> CMD_ERR_O && ERR_CODE_O == ERR_WRONG_MODE &&
      $stable(MODE_DISPLAY_O) && $stable(MODE_SELECT_O) && OBJ_NACK_O)
      else $error("unsupported mode not refused");

   a_mode_chg_target: assert property (
      s_good_mode_change |=> STATUS_WORD_O[SW_TARGET] &&
      EXT_STATUS_O[VS_TARGET] && MODE_DISPLAY_O == $past(OBJ_WDATA_I[7:0]))
      else $error("mode change did not set target reached");

   a_ext_mirror: assert property (
      EXT_STATUS_O[15:0] == STATUS_WORD_O && !EXT_STATUS_O[VS_RESERVED])
      else $error("extended status low half differs");

   a_qstop_low: assert property (
      CE_I && DRIVE_STATE_I == DS_QSTOP_ACTIVE |=>
      !STATUS_WORD_O[SW_QSTOP] && STATUS_WORD_O[2:0] == 3'h7)
      else $error("quick stop bit not low");

   a_fault_sticky: assert property (
      CE_I && FAULT_I |=> STATUS_WORD_O[SW_FAULT] && EXT_STATUS_O[VS_FAULT])
      else $error("fault bit not set");

   a_fault_hold: assert property (
      CE_I && FAULT_I ##1 (!CE_I || !FAULT_RESET_CTRL_I) [*2] |->
      STATUS_WORD_O[SW_FAULT])
      else $error("fault bit lost without reset");

   a_voltage_bit: assert property (
      CE_I |=> STATUS_WORD_O[SW_VOLTAGE] == $past(HV_PRESENT_I))
      else $error("voltage bit wrong");

endmodule : dsmo_status_mode

// *** verification/dsmo_master_model.sv ***
/*
 Object server model: issues one object access at a time.
 Assumes the block answers an access within a few cycles.
*/
`timescale 1ns/100ps
module dsmo_master_model (
   // Clock, reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Object access
   output logic req_o,
   output logic we_o,
   output logic [15:0] index_o,
   output logic [31:0] wdata_o,
   input wire logic ack_i,
   input wire logic nack_i,
   input wire logic [31:0] rdata_i
);
   initial begin
      req_o = 1'b0;
      we_o = 1'b0;
      index_o = 16'h0;
      wdata_o = 32'h0;
   end
   // Request is a pulse; index and data stay until the answer is seen
   task automatic access(input logic we, input logic [15:0] idx,
         input logic [31:0] wd, output logic [31:0] rd, output logic nk);
      int n;
      n = 0;
      @(posedge clk_i);
      req_o <= 1'b1;
      we_o <= we;
      index_o <= idx;
      wdata_o <= wd;
      @(posedge clk_i);
      req_o <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 16);
      rd = rdata_i;
      nk = nack_i;
      // A missing answer poisons the result so the caller's check fails
      if (ack_i !== 1'b1) begin
         rd = 'x;
         nk = 1'bx;
      end
      // Released lines must not keep showing the old value
      we_o <= ~we;
      index_o <= ~idx;
      wdata_o <= ~wd;
   endtask : access
endmodule : dsmo_master_model

// *** verification/test_drive_status_and_mode_objects.sv ***
/*
 Self-checking bench for the status and mode objects block.
 Assumes the object server model carries every object access.
*/
`timescale 1ns/100ps
module test_drive_status_and_mode_objects;
   import dsmo_pkg::*;
   logic CLK_I, OBJ_REQ_I, OBJ_WE_I, OBJ_ACK_O, OBJ_NACK_O, CMD_ERR_O;
   logic RST_N_I = 1'b0, CE_I = 1'b1, FUNC_ACCEPT_O;
   logic [15:0] OBJ_INDEX_I, ERR_CODE_O, STATUS_WORD_O;
   logic [31:0] OBJ_WDATA_I, OBJ_RDATA_O, EXT_STATUS_O, rd;
   logic [2:0] DRIVE_STATE_I = 3'h0;
   logic POWER_ON_I = 1'b0, EVENT_HIT_I = 1'b0, INT_LIMIT_I = 1'b0;
   logic REMOTE_I = 1'b0, HV_PRESENT_I = 1'b0, FAULT_I = 1'b0;
   logic FAULT_RESET_CTRL_I = 1'b0, FUNC_CALL_I = 1'b0;
   logic FUNC_DONE_I = 1'b0, FUNC_ABORT_I = 1'b0, HALT_I = 1'b0;
   logic SETPOINT_REACHED_I = 1'b0, NEW_TARGET_I = 1'b0;
   logic QSTOP_DONE_I = 1'b0, STANDSTILL_I = 1'b0, CAM_REACHED_I = 1'b0;
   logic GEAR_REACHED_I = 1'b0, DRV_OVL_WARN_I = 1'b0, CAPTURE_I = 1'b0;
   logic MOT_OVL_WARN_I = 1'b0, LIM_NEG_I = 1'b0, LIM_POS_I = 1'b0;
   logic AUTOSTART_MODE_I = 1'b0, INIT_DONE_I = 1'b0, nk, ok;
   logic [1:0] MODE_BITS_I = 2'h0;
   logic [3:0] QS_OPTION_I = 4'h0, POS_TRIG_I = 4'h0;
   logic signed [7:0] MODE_SELECT_O, MODE_DISPLAY_O, c, sel;
   logic [2:0] st [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
   logic [15:0] ex [8] = '{16'h00, 16'h40, 16'h21, 16'h23, 16'h27, 16'h07,
      16'h0f, 16'h08};
   logic [7:0] codes [20] = '{8'h80, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe,
      8'hff, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h09, 8'h0a, 8'h0b, 8'h7f};
   int n_fail = 0;
   int checked = 0;

   dsmo_status_mode #(.QS_OPT_W(4)) dsmo_status_mode_inst (.*);
   dsmo_master_model dsmo_master_model_inst (.clk_i(CLK_I),
      .rst_n_i(RST_N_I), .req_o(OBJ_REQ_I), .we_o(OBJ_WE_I),
      .index_o(OBJ_INDEX_I), .wdata_o(OBJ_WDATA_I), .ack_i(OBJ_ACK_O),
      .nack_i(OBJ_NACK_O), .rdata_i(OBJ_RDATA_O));

   initial begin
      CLK_I = 1'b0;
      forever #4 CLK_I = ~CLK_I;
   end

   task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic check_bit(string what, logic exp, logic got);
      check_val(what, {31'h0, exp}, {31'h0, got});
   endtask : check_bit

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // Two edges cover the status register with one cycle to spare
   task automatic settle();
      repeat (2) @(posedge CLK_I);
      #1;
   endtask : settle

   task automatic clear_target();
      @(posedge CLK_I);
      NEW_TARGET_I <= 1'b1;
      @(posedge CLK_I);
      NEW_TARGET_I <= 1'b0;
      settle();
      check_bit("target clear", 1'b0, STATUS_WORD_O[SW_TARGET]);
   endtask : clear_target

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge CLK_I);
      n_fail++;
      finish_test();
   end

   initial begin
      repeat (6) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      settle();
      check_val("select reset", 32'h0, 32'(MODE_SELECT_O));
      for (int s = 0; s < 8; s++) begin
         @(posedge CLK_I);
         DRIVE_STATE_I <= st[s];
         settle();
         check_val("state", ex[s], STATUS_WORD_O & 16'h6f);
         check_val("ext low", STATUS_WORD_O, EXT_STATUS_O[15:0]);
      end
      @(posedge CLK_I);
      DRIVE_STATE_I <= 3'h6;
      POWER_ON_I <= 1'b1;
      EVENT_HIT_I <= 1'b1;
      MODE_BITS_I <= 2'h2;
      INT_LIMIT_I <= 1'b1;
      REMOTE_I <= 1'b1;
      HV_PRESENT_I <= 1'b1;
      settle();
      check_val("status", 16'hea37, STATUS_WORD_O);
      dsmo_master_model_inst.access(1'b0, IDX_STATUS_WORD, 32'h0, rd, nk);
      check_val("status read", 32'h0000ea37, rd);
      // Clock enable low must freeze the status snapshot
      @(posedge CLK_I);
      CE_I <= 1'b0;
      POWER_ON_I <= 1'b0;
      settle();
      check_val("frozen", 16'hea37, STATUS_WORD_O);
      @(posedge CLK_I);
      CE_I <= 1'b1;
      POWER_ON_I <= 1'b1;
      @(posedge CLK_I);
      {CAM_REACHED_I, GEAR_REACHED_I, DRV_OVL_WARN_I} <= 3'h7;
      {MOT_OVL_WARN_I, CAPTURE_I, LIM_NEG_I, LIM_POS_I} <= 4'hf;
      {AUTOSTART_MODE_I, INIT_DONE_I, POS_TRIG_I} <= 6'h3f;
      settle();
      dsmo_master_model_inst.access(1'b0, IDX_EXT_STATUS, 32'h0, rd, nk);
      check_val("ext read", 32'h5dffea37, rd);
      dsmo_master_model_inst.access(1'b1, IDX_EXT_STATUS, 32'h0, rd, nk);
      check_bit("ext write", 1'b1, nk);
      dsmo_master_model_inst.access(1'b0, 16'h1234, 32'h0, rd, nk);
      check_bit("unmapped", 1'b1, nk);
      // Function call, refused second call, completion
      @(posedge CLK_I);
      FUNC_CALL_I <= 1'b1;
      #1 check_bit("accept", 1'b1, FUNC_ACCEPT_O);
      @(posedge CLK_I);
      FUNC_CALL_I <= 1'b0;
      #1 check_bit("busy", 1'b1, STATUS_WORD_O[SW_FUNC_BUSY]);
      @(posedge CLK_I);
      FUNC_CALL_I <= 1'b1;
      #1 check_bit("accept busy", 1'b0, FUNC_ACCEPT_O);
      @(posedge CLK_I);
      FUNC_CALL_I <= 1'b0;
      FUNC_DONE_I <= 1'b1;
      #1 check_bit("cmd err", 1'b1, CMD_ERR_O);
      check_bit("warning", 1'b1, STATUS_WORD_O[SW_WARNING]);
      @(posedge CLK_I);
      FUNC_DONE_I <= 1'b0;
      #1 check_bit("done", 1'b0, STATUS_WORD_O[SW_FUNC_BUSY]);
      @(posedge CLK_I);
      FUNC_CALL_I <= 1'b1;
      @(posedge CLK_I);
      {FUNC_CALL_I, FUNC_ABORT_I} <= 2'h1;
      @(posedge CLK_I);
      FUNC_ABORT_I <= 1'b0;
      #1 check_bit("aborted", 1'b0, STATUS_WORD_O[SW_FUNC_BUSY]);
      // Fault latch and its clearing edge
      @(posedge CLK_I);
      FAULT_I <= 1'b1;
      @(posedge CLK_I);
      FAULT_I <= 1'b0;
      settle();
      check_bit("fault held", 1'b1, STATUS_WORD_O[SW_FAULT]);
      @(posedge CLK_I);
      FAULT_RESET_CTRL_I <= 1'b1;
      settle();
      check_bit("fault clr", 1'b0, STATUS_WORD_O[SW_FAULT]);
      check_bit("warn clr", 1'b0, STATUS_WORD_O[SW_WARNING]);
      @(posedge CLK_I);
      FAULT_RESET_CTRL_I <= 1'b0;
      // Target reached sources
      clear_target();
      @(posedge CLK_I);
      SETPOINT_REACHED_I <= 1'b1;
      settle();
      check_bit("setpoint", 1'b1, STATUS_WORD_O[SW_TARGET]);
      check_bit("ext target", 1'b1, EXT_STATUS_O[VS_TARGET]);
      @(posedge CLK_I);
      SETPOINT_REACHED_I <= 1'b0;
      for (int o = 4; o < 9; o++) begin
         clear_target();
         @(posedge CLK_I);
         QS_OPTION_I <= 4'(o);
         {QSTOP_DONE_I, STANDSTILL_I} <= 2'h3;
         settle();
         check_bit("qs target", o > 4, STATUS_WORD_O[SW_TARGET]);
         @(posedge CLK_I);
         {QSTOP_DONE_I, STANDSTILL_I} <= 2'h0;
      end
      clear_target();
      @(posedge CLK_I);
      {HALT_I, STANDSTILL_I} <= 2'h3;
      settle();
      check_bit("halt target", 1'b1, STATUS_WORD_O[SW_TARGET]);
      @(posedge CLK_I);
      {HALT_I, STANDSTILL_I} <= 2'h0;
      clear_target();
      // Twenty mode codes from -128 to 127, reserved ones refused
      sel = 8'h00;
      for (int i = 0; i < 20; i++) begin
         c = signed'(codes[i]);
         ok = (c >= -5 && c <= 1) || c == 3 || (c >= 6 && c <= 10);
         dsmo_master_model_inst.access(1'b1, IDX_MODE_SELECT, 32'(c), rd, nk);
         check_bit("mode refused", !ok, nk);
         if (ok) begin
            sel = c;
         end else begin
            check_val("err code", 32'hff04, 32'(ERR_CODE_O));
         end
         check_val("select", 32'(sel), 32'(MODE_SELECT_O));
         if (ok && c != 0) begin
            check_val("display", 32'(c), 32'(MODE_DISPLAY_O));
         end
         if (i == 2) begin
            check_bit("mode target", 1'b1, STATUS_WORD_O[SW_TARGET]);
         end
      end
      dsmo_master_model_inst.access(1'b0, IDX_MODE_DISPLAY, 32'h0, rd, nk);
      check_val("display read", 32'h0000000a, rd);
      dsmo_master_model_inst.access(1'b0, IDX_MODE_SELECT, 32'h0, rd, nk);
      check_val("select read", 32'h0000000a, rd);
      dsmo_master_model_inst.access(1'b1, IDX_MODE_DISPLAY, 32'h1, rd, nk);
      check_bit("display write", 1'b1, nk);
      finish_test();
   end
endmodule : test_drive_status_and_mode_objects
